// File: rtl/dsup_top.sv
// drive run supervisor: run control, dormancy, timers, fan and start guard
//
// Added by the designer: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
`include "dsup_cfg.svh"

module dsup_top import dsup_pkg::*; #(
	parameter int TICK_CYCLES = `DSUP_TICK_CYCLES
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic [11:0] di_pin,
	input wire logic fault_reset,
	input wire logic [15:0] set_freq,
	input wire logic [7:0] heatsink_temp,
	input wire logic [12:0] analog_input_one,
	input wire logic [12:0] analog_input_two,
	input wire logic [12:0] analog_input_three,
	output logic motor_run,
	output logic motor_reverse,
	output logic fan_on,
	output logic dormant,
	output logic run_time_reached,
	output logic timer_reached,
	output logic this_run_reached
);

	dsup_tick_t tick;
	dsup_cmd_t cmd;
	dsup_state_t state_q, state_d;
	logic [`DSUP_CTRL_W-1:0] ctrl_q, ctrl_d;
	logic [15:0] run_time_reach_hours_q, run_time_reach_hours_d;
	logic [15:0] sleep_freq_threshold_q, sleep_freq_threshold_d;
	logic [15:0] sleep_delay_q, sleep_delay_d;
	logic [15:0] wake_freq_threshold_q, wake_freq_threshold_d;
	logic [15:0] wake_delay_q, wake_delay_d;
	logic [15:0] run_timer_duration_q, run_timer_duration_d;
	logic [15:0] this_run_time_threshold_q, this_run_time_threshold_d;
	logic [11:0][5:0] di_func_q, di_func_d;
	logic act_q, wr_q, rd_pend_q;
	logic [7:0] addr_q;
	logic [31:0] hrdata_q, hrdata_d, rd_mux;
	logic [15:0] sleep_cnt_q, sleep_cnt_d, wake_cnt_q, wake_cnt_d;
	logic [15:0] run_min_q, run_min_d;
	logic [15:0] accumulated_run_hours_q, accumulated_run_hours_d;
	logic [9:0] hour_sub_q, hour_sub_d;
	logic [15:0] timer_remaining_monitor_q, timer_remaining_monitor_d;
	logic guard_q, guard_d, fan_q, fan_d, latch_q, latch_d, dir_q, dir_d;
	logic fwd_prev_q, rev_prev_q, tmr_flag_q, tmr_flag_d;
	logic run_q, rev_out_q, rt_q, this_q;
	logic run_req, run_dir, guard_block, dorm_en, start, run_coded, run_coded_q;
	logic sleep_cond, wake_cond, sleep_hit, wake_hit, tmr_hit, rt_hit, this_hit;
	logic [12:0] ai_sel;
	logic [28:0] dur_prod;
	logic [15:0] dur_eff;

	// ********************************************************************
	// time base and input terminals
	// ********************************************************************
	dsup_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
		.core_clk(core_clk),
		.rst(rst),
		.tick(tick)
	);

	dsup_din u_din (
		.core_clk(core_clk),
		.rst(rst),
		.di_pin(di_pin),
		.di_func(di_func_q),
		.cmd(cmd)
	);

	// ********************************************************************
	// ahb-lite slave
	// ********************************************************************
	// read mux for the address held from the address phase
	always_comb begin
		rd_mux = 32'h0000_0000;
		case (addr_q)
			`DSUP_OFF_CTRL: rd_mux = {25'h000_0000, ctrl_q};
			`DSUP_OFF_RUN_HOURS: rd_mux = {16'h0000, run_time_reach_hours_q};
			`DSUP_OFF_SLEEP_FREQ: rd_mux = {16'h0000, sleep_freq_threshold_q};
			`DSUP_OFF_SLEEP_DELAY: rd_mux = {16'h0000, sleep_delay_q};
			`DSUP_OFF_WAKE_FREQ: rd_mux = {16'h0000, wake_freq_threshold_q};
			`DSUP_OFF_WAKE_DELAY: rd_mux = {16'h0000, wake_delay_q};
			`DSUP_OFF_TMR_DUR: rd_mux = {16'h0000, run_timer_duration_q};
			`DSUP_OFF_THIS_RUN: rd_mux = {16'h0000, this_run_time_threshold_q};
			`DSUP_OFF_DI_FUNC0: rd_mux = {2'b00, di_func_q[3], 2'b00, di_func_q[2],
				2'b00, di_func_q[1], 2'b00, di_func_q[0]};
			`DSUP_OFF_DI_FUNC1: rd_mux = {2'b00, di_func_q[7], 2'b00, di_func_q[6],
				2'b00, di_func_q[5], 2'b00, di_func_q[4]};
			`DSUP_OFF_DI_FUNC2: rd_mux = {2'b00, di_func_q[11], 2'b00, di_func_q[10],
				2'b00, di_func_q[9], 2'b00, di_func_q[8]};
			`DSUP_OFF_STATUS: rd_mux = {24'h00_0000, guard_block, this_q, tmr_flag_q, rt_q,
				fan_q, run_q, state_q};
			`DSUP_OFF_REMAIN: rd_mux = {16'h0000, timer_remaining_monitor_q};
			`DSUP_OFF_ACC_HOURS: rd_mux = {16'h0000, accumulated_run_hours_q};
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// register writes in the data phase, read data one wait cycle later
	always_comb begin
		ctrl_d = ctrl_q;
		run_time_reach_hours_d = run_time_reach_hours_q;
		sleep_freq_threshold_d = sleep_freq_threshold_q;
		sleep_delay_d = sleep_delay_q;
		wake_freq_threshold_d = wake_freq_threshold_q;
		wake_delay_d = wake_delay_q;
		run_timer_duration_d = run_timer_duration_q;
		this_run_time_threshold_d = this_run_time_threshold_q;
		di_func_d = di_func_q;
		hrdata_d = hrdata_q;
		if (rd_pend_q) begin
			hrdata_d = rd_mux;
		end
		if (act_q && wr_q) begin
			case (addr_q)
				`DSUP_OFF_CTRL: ctrl_d = hwdata[`DSUP_CTRL_W-1:0];
				`DSUP_OFF_RUN_HOURS: run_time_reach_hours_d = hwdata[15:0];
				`DSUP_OFF_SLEEP_FREQ: sleep_freq_threshold_d = hwdata[15:0];
				`DSUP_OFF_SLEEP_DELAY: sleep_delay_d = hwdata[15:0];
				`DSUP_OFF_WAKE_FREQ: wake_freq_threshold_d = hwdata[15:0];
				`DSUP_OFF_WAKE_DELAY: wake_delay_d = hwdata[15:0];
				`DSUP_OFF_TMR_DUR: run_timer_duration_d = hwdata[15:0];
				`DSUP_OFF_THIS_RUN: this_run_time_threshold_d = hwdata[15:0];
				`DSUP_OFF_DI_FUNC0: di_func_d[3:0] = {hwdata[29:24], hwdata[21:16], hwdata[13:8], hwdata[5:0]};
				`DSUP_OFF_DI_FUNC1: di_func_d[7:4] = {hwdata[29:24], hwdata[21:16], hwdata[13:8], hwdata[5:0]};
				`DSUP_OFF_DI_FUNC2: di_func_d[11:8] = {hwdata[29:24], hwdata[21:16], hwdata[13:8], hwdata[5:0]};
				default: ;
			endcase
		end
	end

	// register file and bus phase flops
	always_ff @(posedge core_clk) begin
		if (rst) begin
			ctrl_q <= `DSUP_CTRL_RST;
			run_time_reach_hours_q <= `DSUP_HALF_RST;
			sleep_freq_threshold_q <= `DSUP_HALF_RST;
			sleep_delay_q <= `DSUP_HALF_RST;
			wake_freq_threshold_q <= `DSUP_HALF_RST;
			wake_delay_q <= `DSUP_HALF_RST;
			run_timer_duration_q <= `DSUP_HALF_RST;
			this_run_time_threshold_q <= `DSUP_HALF_RST;
			di_func_q <= {12{`DSUP_DI_FUNC_RST}};
			hrdata_q <= 32'h0000_0000;
			act_q <= 1'b0;
			wr_q <= 1'b0;
			rd_pend_q <= 1'b0;
			addr_q <= 8'h00;
		end else begin
			ctrl_q <= ctrl_d;
			run_time_reach_hours_q <= run_time_reach_hours_d;
			sleep_freq_threshold_q <= sleep_freq_threshold_d;
			sleep_delay_q <= sleep_delay_d;
			wake_freq_threshold_q <= wake_freq_threshold_d;
			wake_delay_q <= wake_delay_d;
			run_timer_duration_q <= run_timer_duration_d;
			this_run_time_threshold_q <= this_run_time_threshold_d;
			di_func_q <= di_func_d;
			hrdata_q <= hrdata_d;
			act_q <= hsel && htrans[1] && hready;
			wr_q <= hwrite;
			rd_pend_q <= hsel && htrans[1] && hready && !hwrite;
			if (hsel && htrans[1] && hready) begin
				addr_q <= haddr[7:0];
			end
		end
	end

	// reads stall one cycle so the data leave a flop
	assign hreadyout = !rd_pend_q;
	assign hresp = 1'b0;
	assign hrdata = hrdata_q;

	// ********************************************************************
	// run command, guard, conditions
	// ********************************************************************
	// two-wire or three-wire command, guard blocks stale commands
	always_comb begin
		latch_d = latch_q;
		dir_d = dir_q;
		if (cmd.forward_run_input && !fwd_prev_q) begin
			latch_d = 1'b1;
			dir_d = 1'b0;
		end else if (cmd.reverse_run_input && !rev_prev_q) begin
			latch_d = 1'b1;
			dir_d = 1'b1;
		end
		// a latch left over from two-wire use must not start the drive in three-wire mode
		if (!cmd.three_stop || !cmd.three_mode) begin
			latch_d = 1'b0;
		end
		run_req = cmd.three_mode ? latch_q : (cmd.forward_run_input | cmd.reverse_run_input);
		run_dir = cmd.three_mode ? dir_q : (cmd.reverse_run_input & !cmd.forward_run_input);
		// any terminal coded for running, delayed one cycle to line up with the decode
		run_coded = 1'b0;
		for (int i = 0; i < 12; i++) begin
			if (di_func_q[i] == `DSUP_FN_FWD || di_func_q[i] == `DSUP_FN_REV) begin
				run_coded = 1'b1;
			end
		end
		// guard drops only once a run-coded terminal is seen idle
		guard_d = guard_q;
		if (!run_req && run_coded_q) begin
			guard_d = 1'b0;
		end
		if (fault_reset) begin
			guard_d = 1'b1;
		end
		guard_block = ctrl_q[`DSUP_CTRL_GUARD] & guard_q;
		dorm_en = (sleep_freq_threshold_q != 16'h0000) || (wake_freq_threshold_q != 16'h0000);
		sleep_cond = dorm_en && (set_freq <= sleep_freq_threshold_q);
		wake_cond = dorm_en && (set_freq >= wake_freq_threshold_q);
		sleep_hit = sleep_cond && (sleep_cnt_q >= sleep_delay_q);
		wake_hit = wake_cond && (wake_cnt_q >= wake_delay_q);
		case (ctrl_q[`DSUP_CTRL_SRC_HI:`DSUP_CTRL_SRC_LO])
			2'b01: ai_sel = analog_input_one;
			2'b10: ai_sel = analog_input_two;
			2'b11: ai_sel = analog_input_three;
			default: ai_sel = `DSUP_AI_FULL;
		endcase
		if (ai_sel > `DSUP_AI_FULL) begin
			ai_sel = `DSUP_AI_FULL;
		end
		dur_prod = 29'(run_timer_duration_q * ai_sel);
		dur_eff = dur_prod[27:12];
		tmr_hit = ctrl_q[`DSUP_CTRL_TMR_EN] && (run_min_q >= dur_eff);
		rt_hit = (run_time_reach_hours_q != 16'h0000) &&
			(accumulated_run_hours_q >= run_time_reach_hours_q);
		this_hit = (this_run_time_threshold_q != 16'h0000) &&
			(run_min_q >= this_run_time_threshold_q);
	end

	// ********************************************************************
	// run state machine and timers
	// ********************************************************************
	// state transitions, startup clears the per-run timer
	always_comb begin
		state_d = state_q;
		start = 1'b0;
		tmr_flag_d = tmr_flag_q;
		case (state_q)
			ST_STOP: begin
				if (run_req && !guard_block) begin
					state_d = ST_RUN;
					start = 1'b1;
				end
			end
			ST_RUN: begin
				if (!run_req) begin
					state_d = ST_STOP;
				end else if (tmr_hit) begin
					state_d = ST_HALT;
					tmr_flag_d = 1'b1;
				end else if (rt_hit && ctrl_q[`DSUP_CTRL_ACTION]) begin
					state_d = ST_HALT;
				end else if (sleep_hit) begin
					state_d = ST_DORMANT;
				end
			end
			ST_DORMANT: begin
				if (!run_req) begin
					state_d = ST_STOP;
				end else if (wake_hit) begin
					state_d = ST_RUN;
					start = 1'b1;
				end
			end
			ST_HALT: begin
				if (!run_req) begin
					state_d = ST_STOP;
				end
			end
			default: state_d = ST_STOP;
		endcase
		if (start) begin
			tmr_flag_d = 1'b0;
		end
		sleep_cnt_d = 16'h0000;
		if (state_q == ST_RUN && sleep_cond) begin
			sleep_cnt_d = sleep_cnt_q + {15'h0000, tick.tenth_sec && sleep_cnt_q != 16'hFFFF};
		end
		wake_cnt_d = 16'h0000;
		if (state_q == ST_DORMANT && wake_cond) begin
			wake_cnt_d = wake_cnt_q + {15'h0000, tick.tenth_sec && wake_cnt_q != 16'hFFFF};
		end
		run_min_d = run_min_q;
		if (start) begin
			run_min_d = 16'h0000;
		end else if (state_q == ST_RUN && tick.tenth_min && run_min_q != 16'hFFFF) begin
			run_min_d = run_min_q + 16'h0001;
		end
		timer_remaining_monitor_d = (dur_eff > run_min_q) ? dur_eff - run_min_q : 16'h0000;
		hour_sub_d = hour_sub_q;
		accumulated_run_hours_d = accumulated_run_hours_q;
		if (state_q == ST_RUN && tick.tenth_min) begin
			hour_sub_d = hour_sub_q + 10'h001;
			if (hour_sub_q == `DSUP_TENTH_MIN_PER_HOUR - 10'h001) begin
				hour_sub_d = 10'h000;
				if (accumulated_run_hours_q != 16'hFFFF) begin
					accumulated_run_hours_d = accumulated_run_hours_q + 16'h0001;
				end
			end
		end
		fan_d = fan_q;
		if (ctrl_q[`DSUP_CTRL_FAN] || state_q == ST_RUN) begin
			fan_d = 1'b1;
		end else if (heatsink_temp > `DSUP_FAN_TEMP) begin
			fan_d = 1'b1;
		end else if (heatsink_temp < `DSUP_FAN_TEMP) begin
			fan_d = 1'b0;
		end
	end

	// register state, counters and outputs
	always_ff @(posedge core_clk) begin
		if (rst) begin
			state_q <= ST_STOP;
			guard_q <= 1'b1;
			run_coded_q <= 1'b0;
			latch_q <= 1'b0;
			dir_q <= 1'b0;
			fwd_prev_q <= 1'b0;
			rev_prev_q <= 1'b0;
			tmr_flag_q <= 1'b0;
			sleep_cnt_q <= 16'h0000;
			wake_cnt_q <= 16'h0000;
			run_min_q <= 16'h0000;
			timer_remaining_monitor_q <= 16'h0000;
			hour_sub_q <= 10'h000;
			accumulated_run_hours_q <= 16'h0000;
			fan_q <= 1'b0;
			run_q <= 1'b0;
			rev_out_q <= 1'b0;
			rt_q <= 1'b0;
			this_q <= 1'b0;
		end else begin
			state_q <= state_d;
			guard_q <= guard_d;
			run_coded_q <= run_coded;
			latch_q <= latch_d;
			dir_q <= dir_d;
			fwd_prev_q <= cmd.forward_run_input;
			rev_prev_q <= cmd.reverse_run_input;
			tmr_flag_q <= tmr_flag_d;
			sleep_cnt_q <= sleep_cnt_d;
			wake_cnt_q <= wake_cnt_d;
			run_min_q <= run_min_d;
			timer_remaining_monitor_q <= timer_remaining_monitor_d;
			hour_sub_q <= hour_sub_d;
			accumulated_run_hours_q <= accumulated_run_hours_d;
			fan_q <= fan_d;
			run_q <= (state_d == ST_RUN);
			rev_out_q <= run_dir;
			rt_q <= rt_hit;
			this_q <= this_hit && (state_q == ST_RUN);
		end
	end

	assign motor_run = run_q;
	assign motor_reverse = rev_out_q;
	assign fan_on = fan_q;
	assign dormant = (state_q == ST_DORMANT);
	assign run_time_reached = rt_q;
	assign timer_reached = tmr_flag_q;
	assign this_run_reached = this_q;

	// ********************************************************************
	// checks
	// ********************************************************************
	fan_always_a: assert property (@(posedge core_clk) disable iff (rst)
		ctrl_q[`DSUP_CTRL_FAN] |=> fan_on) else $error("fan off in always-on mode");
	fan_running_a: assert property (@(posedge core_clk) disable iff (rst)
		(state_q == ST_RUN) |=> fan_on) else $error("fan off while running");
	guard_hold_a: assert property (@(posedge core_clk) disable iff (rst)
		(state_q == ST_STOP && guard_block) |=> !motor_run) else $error("guarded command started the drive");
	sleep_entry_a: assert property (@(posedge core_clk) disable iff (rst)
		(state_q == ST_RUN && run_req && sleep_hit && !tmr_hit && !(rt_hit && ctrl_q[`DSUP_CTRL_ACTION]))
		|=> dormant) else $error("dormant state not entered");
	dorm_off_a: assert property (@(posedge core_clk) disable iff (rst)
		(state_q == ST_RUN && !dorm_en) |=> !dormant) else $error("dormant with both thresholds zero");
	timer_stop_a: assert property (@(posedge core_clk) disable iff (rst)
		(state_q == ST_RUN && run_req && tmr_hit) |=> (!motor_run && timer_reached) [*2])
		else $error("timer expiry did not stop the drive");
	start_clear_a: assert property (@(posedge core_clk) disable iff (rst)
		start |=> (run_min_q == 16'h0000 && !timer_reached)) else $error("run timer not cleared at start");
	rt_action_a: assert property (@(posedge core_clk) disable iff (rst)
		(state_q == ST_RUN && run_req && rt_hit && ctrl_q[`DSUP_CTRL_ACTION]) |=> state_q == ST_HALT)
		else $error("hours reached did not stop the drive");
	this_run_a: assert property (@(posedge core_clk) disable iff (rst)
		(state_q == ST_RUN && this_hit) |=> this_run_reached) else $error("run time flag missing");

endmodule : dsup_top

// File: rtl/dsup_cfg.svh
// offsets, field positions, reset values and timing counts of the drive run supervisor
`ifndef DSUP_CFG_SVH
`define DSUP_CFG_SVH

// ********************************************************************
// register byte offsets
// ********************************************************************
`define DSUP_OFF_CTRL 8'h00
`define DSUP_OFF_RUN_HOURS 8'h04
`define DSUP_OFF_SLEEP_FREQ 8'h08
`define DSUP_OFF_SLEEP_DELAY 8'h0C
`define DSUP_OFF_WAKE_FREQ 8'h10
`define DSUP_OFF_WAKE_DELAY 8'h14
`define DSUP_OFF_TMR_DUR 8'h18
`define DSUP_OFF_THIS_RUN 8'h1C
`define DSUP_OFF_DI_FUNC0 8'h20
`define DSUP_OFF_DI_FUNC1 8'h24
`define DSUP_OFF_DI_FUNC2 8'h28
`define DSUP_OFF_STATUS 8'h2C
`define DSUP_OFF_REMAIN 8'h30
`define DSUP_OFF_ACC_HOURS 8'h34

// ********************************************************************
// control register fields
// ********************************************************************
`define DSUP_CTRL_ACTION 0
`define DSUP_CTRL_FAN 1
`define DSUP_CTRL_TMR_EN 2
`define DSUP_CTRL_SRC_LO 4
`define DSUP_CTRL_SRC_HI 5
`define DSUP_CTRL_GUARD 6
`define DSUP_CTRL_W 7

// ********************************************************************
// reset values
// ********************************************************************
`define DSUP_CTRL_RST 7'h00
`define DSUP_HALF_RST 16'h0000
`define DSUP_DI_FUNC_RST 6'h00

// ********************************************************************
// codes, limits and timing
// ********************************************************************
`define DSUP_FN_NONE 6'h00
`define DSUP_FN_FWD 6'h01
`define DSUP_FN_REV 6'h02
`define DSUP_FN_THREE 6'h03
`define DSUP_FAN_TEMP 8'h28
`define DSUP_AI_FULL 13'h1000
`define DSUP_CLK_PERIOD_NS 10
`define DSUP_TICK_PERIOD_NS 100000000
`define DSUP_TICK_CYCLES (`DSUP_TICK_PERIOD_NS / `DSUP_CLK_PERIOD_NS)
`define DSUP_TICKS_PER_TENTH_MIN 6'h3C
`define DSUP_TENTH_MIN_PER_HOUR 10'h258

`endif

// File: rtl/dsup_pkg.sv
// types shared by the drive run supervisor modules
package dsup_pkg;

	// run control states
	typedef enum logic [1:0] {
		ST_STOP = 2'b00,
		ST_RUN = 2'b01,
		ST_DORMANT = 2'b10,
		ST_HALT = 2'b11
	} dsup_state_t;

	// decoded run command lines from the input terminals
	typedef struct packed {
		logic forward_run_input;
		logic reverse_run_input;
		logic three_stop;
		logic three_mode;
	} dsup_cmd_t;

	// time base pulses
	typedef struct packed {
		logic tenth_sec;
		logic tenth_min;
	} dsup_tick_t;

endpackage : dsup_pkg

// File: rtl/dsup_tick.sv
// time base: tenth-second and tenth-minute enable pulses
`timescale 1ns/1ns
`include "dsup_cfg.svh"

module dsup_tick import dsup_pkg::*; #(
	parameter int TICK_CYCLES = `DSUP_TICK_CYCLES
) (
	input wire logic core_clk,
	input wire logic rst,
	output dsup_tick_t tick
);

	logic [23:0] cyc_q, cyc_d;
	logic [5:0] sec_q, sec_d;
	dsup_tick_t tick_q, tick_d;

	// ********************************************************************
	// divider chain
	// ********************************************************************
	// next values of the cycle and tenth-second counters
	always_comb begin
		cyc_d = cyc_q + 24'h00_0001;
		sec_d = sec_q;
		tick_d = '0;
		if (cyc_q == 24'(TICK_CYCLES - 1)) begin
			cyc_d = 24'h00_0000;
			tick_d.tenth_sec = 1'b1;
			sec_d = sec_q + 6'h01;
			if (sec_q == `DSUP_TICKS_PER_TENTH_MIN - 6'h01) begin
				sec_d = 6'h00;
				tick_d.tenth_min = 1'b1;
			end
		end
	end

	// register the divider
	always_ff @(posedge core_clk) begin
		if (rst) begin
			cyc_q <= 24'h00_0000;
			sec_q <= 6'h00;
			tick_q <= '0;
		end else begin
			cyc_q <= cyc_d;
			sec_q <= sec_d;
			tick_q <= tick_d;
		end
	end

	assign tick = tick_q;

endmodule : dsup_tick

// File: rtl/dsup_din.sv
// input terminal synchroniser and function decoder
`timescale 1ns/1ns
`include "dsup_cfg.svh"

module dsup_din import dsup_pkg::*; (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [11:0] di_pin,
	input wire logic [11:0][5:0] di_func,
	output dsup_cmd_t cmd
);

	logic [11:0] sync1_q;
	logic [11:0] sync2_q;
	dsup_cmd_t cmd_q, cmd_d;

	// ********************************************************************
	// two-stage synchronisers, one per terminal
	// ********************************************************************
	for (genvar g = 0; g < 12; g++) begin : g_sync
		always_ff @(posedge core_clk) begin
			if (rst) begin
				sync1_q[g] <= 1'b0;
				sync2_q[g] <= 1'b0;
			end else begin
				sync1_q[g] <= di_pin[g];
				sync2_q[g] <= sync1_q[g];
			end
		end
	end

	// ********************************************************************
	// function decode
	// ********************************************************************
	// merge every terminal by its function code, code 0 does nothing
	always_comb begin
		cmd_d = '0;
		cmd_d.three_stop = 1'b1;
		for (int i = 0; i < 12; i++) begin
			case (di_func[i])
				`DSUP_FN_FWD: cmd_d.forward_run_input = cmd_d.forward_run_input | sync2_q[i];
				`DSUP_FN_REV: cmd_d.reverse_run_input = cmd_d.reverse_run_input | sync2_q[i];
				`DSUP_FN_THREE: begin
					cmd_d.three_mode = 1'b1;
					cmd_d.three_stop = cmd_d.three_stop & sync2_q[i];
				end
				default: ;
			endcase
		end
	end

	// register the decoded lines
	always_ff @(posedge core_clk) begin
		if (rst) begin
			cmd_q <= '0;
		end else begin
			cmd_q <= cmd_d;
		end
	end

	assign cmd = cmd_q;

endmodule : dsup_din

// File: tb/dsup_term_model.sv
// terminal and operator model: run, direction and spare input levels
`timescale 1ns/1ns

module dsup_term_model (
	input wire logic core_clk,
	input wire logic run_cmd,
	input wire logic rev_cmd,
	input wire logic [9:0] spare,
	output logic [11:0] di_pin
);
	// ********************************************************************
	// terminal drive
	// ********************************************************************
	// twelve levels; spare ones drive terminals 2 to 11, terminal 2 also as the three-wire stop line
	always_ff @(posedge core_clk) begin
		di_pin <= {spare, rev_cmd, run_cmd};
	end
endmodule : dsup_term_model

// File: tb/drive_run_supervisor_test.sv
// self-checking bench of the drive run supervisor
`timescale 1ns/1ns
`include "dsup_cfg.svh"

module drive_run_supervisor_test import dsup_pkg::*;;
	logic core_clk = 0;
	logic rst = 1;
	logic hsel = 0;
	logic hwrite = 0;
	logic fault_reset = 0;
	logic run_cmd = 0;
	logic rev_cmd = 0;
	logic [31:0] haddr = 0;
	logic [31:0] hwdata = 0;
	logic [31:0] rd;
	logic [1:0] htrans = 0;
	logic [2:0] hsize = 3'h2;
	logic [15:0] set_freq = 0;
	logic [7:0] temp = 0;
	logic [12:0] ai = 0;
	logic [9:0] spare = 0;
	wire logic hreadyout;
	wire logic hresp;
	wire logic [31:0] hrdata;
	wire logic [11:0] di_pin;
	wire logic [6:0] obs;
	int mismatches = 0;
	int n_checks = 0;
	int cnt;

	// ********************************************************************
	// clock, partner and design
	// ********************************************************************
	always #5 core_clk = ~core_clk;
	dsup_term_model u_term (.core_clk(core_clk), .run_cmd(run_cmd), .rev_cmd(rev_cmd), .spare(spare), .di_pin(di_pin));
	dsup_top #(.TICK_CYCLES(10)) u_dut (.core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .di_pin(di_pin), .fault_reset(fault_reset),
		.set_freq(set_freq), .heatsink_temp(temp), .analog_input_one(ai), .analog_input_two(ai),
		.analog_input_three(ai), .motor_run(obs[0]), .motor_reverse(obs[1]), .fan_on(obs[2]),
		.dormant(obs[3]), .run_time_reached(obs[4]), .timer_reached(obs[5]), .this_run_reached(obs[6]));

	// ********************************************************************
	// shared tasks
	// ********************************************************************
	task check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	// one single AHB transfer, address phase then data phase
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		hsel <= 0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		rd = hrdata;
		check(hresp, 0);
	endtask : bus
	task idle(input int n);
		repeat (n) @(posedge core_clk);
	endtask : idle
	// bounded wait for one output level
	task wait_bit(input int b, input logic v, input int lim);
		cnt = 0;
		while (obs[b] !== v && cnt < lim) begin
			@(posedge core_clk);
			cnt++;
		end
		check(obs[b], v);
	endtask : wait_bit
	task end_of_test();
		$display("mismatches=%0d n_checks=%0d", mismatches, n_checks);
		if (mismatches == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : end_of_test

	// ********************************************************************
	// watchdog
	// ********************************************************************
	initial begin
		#1000000;
		mismatches++;
		end_of_test();
	end

	// ********************************************************************
	// scenarios
	// ********************************************************************
	initial begin
		void'($urandom(78699));
		run_cmd = 1;
		idle(16);
		rst <= 0;
		@(posedge core_clk);
		bus(0, `DSUP_OFF_CTRL, 0);
		check(rd, `DSUP_CTRL_RST);
		bus(1, 8'h3C, 32'h5);
		bus(0, 8'h3C, 0);
		check(rd, 0);
		bus(1, `DSUP_OFF_ACC_HOURS, 32'h5);
		bus(0, `DSUP_OFF_ACC_HOURS, 0);
		check(rd, 0);
		// fan policy while stopped
		temp <= 8'd41 + 8'($urandom % 215);
		idle(4);
		check(obs[2], 1);
		temp <= 8'($urandom % 40);
		idle(4);
		check(obs[2], 0);
		bus(1, `DSUP_OFF_CTRL, 32'h2);
		idle(3);
		check(obs[2], 1);
		// start guard against a command held since power-on
		bus(1, `DSUP_OFF_CTRL, 32'h40);
		bus(1, `DSUP_OFF_DI_FUNC0, 32'h0201);
		spare <= 10'($urandom);
		idle(20);
		check(obs[0], 0);
		run_cmd <= 0;
		idle(8);
		run_cmd <= 1;
		wait_bit(0, 1, 10);
		idle(3);
		check(obs[2], 1);
		run_cmd <= 0;
		wait_bit(0, 0, 10);
		fault_reset <= 1;
		run_cmd <= 1;
		idle(8);
		fault_reset <= 0;
		idle(10);
		check(obs[0], 0);
		run_cmd <= 0;
		idle(8);
		run_cmd <= 1;
		wait_bit(0, 1, 10);
		rev_cmd <= 1;
		run_cmd <= 0;
		wait_bit(1, 1, 10);
		check(obs[0], 1);
		rev_cmd <= 0;
		run_cmd <= 0;
		wait_bit(0, 0, 10);
		// three-wire control: a forward pulse latches the run, the stop line ends it
		spare <= 10'h001;
		bus(1, `DSUP_OFF_DI_FUNC0, 32'h0003_0201);
		run_cmd <= 1;
		wait_bit(0, 1, 12);
		run_cmd <= 0;
		idle(8);
		check(obs[0], 1);
		spare <= 10'h000;
		wait_bit(0, 0, 12);
		bus(1, `DSUP_OFF_DI_FUNC0, 32'h0201);
		// run timer over every duration source, analog at half scale
		ai <= 13'h0800;
		bus(1, `DSUP_OFF_TMR_DUR, 2);
		for (int s = 0; s < 4; s++) begin
			bus(1, `DSUP_OFF_CTRL, 32'h4 | (s << 4));
			run_cmd <= 1;
			idle(8);
			bus(0, `DSUP_OFF_REMAIN, 0);
			check(rd, (s == 0) ? 2 : 1);
			wait_bit(5, 1, 1300);
			check((s == 0) ? (cnt > 500) : (cnt <= 620), 1);
			check(obs[0], 0);
			run_cmd <= 0;
			idle(8);
		end
		// dormancy and wakeup
		bus(1, `DSUP_OFF_CTRL, 0);
		bus(1, `DSUP_OFF_SLEEP_FREQ, 100);
		bus(1, `DSUP_OFF_WAKE_FREQ, 200);
		bus(1, `DSUP_OFF_SLEEP_DELAY, 3);
		bus(1, `DSUP_OFF_THIS_RUN, 1);
		set_freq <= 500;
		run_cmd <= 1;
		wait_bit(0, 1, 10);
		set_freq <= 16'($urandom % 101);
		wait_bit(3, 1, 60);
		check(cnt >= 18, 1);
		check(obs[0], 0);
		set_freq <= 16'd200 + 16'($urandom % 1000);
		wait_bit(0, 1, 20);
		bus(1, `DSUP_OFF_SLEEP_FREQ, 0);
		bus(1, `DSUP_OFF_WAKE_FREQ, 0);
		set_freq <= 0;
		idle(60);
		check(obs[3], 0);
		wait_bit(6, 1, 1300);
		check(obs[4], 0);
		end_of_test();
	end
endmodule : drive_run_supervisor_test
